// [bsr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bsr_host_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic slow,
    input wire logic clr,
    // Reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Captured reply
    output logic [7:0] got [0:15],
    output logic [4:0] cnt
);
    // Slow host drops ready every other cycle, so each byte must stand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end
    // Keep accepted bytes in arrival order; stop at 16 to stay in range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 5'h00;
        end else if (clr) begin
            cnt <= 5'h00;
        end else if (tx_valid && tx_ready && cnt != 5'h10) begin
            got[cnt[3:0]] <= tx_data;
            cnt <= cnt + 5'h01;
        end
    end
endmodule
`default_nettype wire

// [bsr_pkg.sv]
`default_nettype none
package bsr_pkg;

    // ************************************************************
    // Status codes carried in each reply
    // ************************************************************
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_UNSUP_CMD = 8'hc0;
    localparam logic [7:0] STS_PACKET = 8'hc1;
    localparam logic [7:0] STS_CHECKSUM = 8'hc2;
    localparam logic [7:0] STS_PARAM = 8'hd0;
    localparam logic [7:0] STS_BAD_ADDR = 8'hd2;
    localparam logic [7:0] STS_CERT_AREA = 8'hd3;
    localparam logic [7:0] STS_NOT_ACCEPTED = 8'hd5;
    localparam logic [7:0] STS_LC_UNMATCHED = 8'hd6;
    localparam logic [7:0] STS_HARDWARE = 8'hd7;
    localparam logic [7:0] STS_PROTECTION = 8'hda;
    localparam logic [7:0] STS_TRUSTED = 8'hdb;
    localparam logic [7:0] STS_SECURE = 8'he4;
    localparam logic [7:0] STS_FLASH_ACCESS = 8'he5;
    localparam logic [7:0] STS_VERIFY = 8'he8;
    localparam logic [7:0] STS_FLASH_INIT = 8'he7;

    // ************************************************************
    // Trusted-system detail words
    // ************************************************************
    localparam logic [31:0] TS_BAD_VERSION = 32'haaaa0101;
    localparam logic [31:0] TS_LEN_RANGE = 32'haaaa0102;
    localparam logic [31:0] TS_MISSING_FIELD = 32'haaaa0103;
    localparam logic [31:0] TS_PAST_END = 32'haaaa0104;
    localparam logic [31:0] TS_IMAGE_LEN = 32'haaaa0105;
    localparam logic [31:0] TS_CRC_CALC = 32'haaaa0200;
    localparam logic [31:0] TS_CRC_MISMATCH = 32'haaaa0300;
    localparam logic [31:0] UNUSED_WORD = 32'hffffffff;

    // ************************************************************
    // Lifecycle state codes
    // ************************************************************
    localparam logic [7:0] LC_MANUFACTURER = 8'h04;
    localparam logic [7:0] LC_LOCKED_BOOT = 8'h06;
    localparam logic [7:0] LC_RETURN_REQ = 8'h07;
    localparam logic [7:0] LC_RETURN_ACK = 8'h08;
    localparam logic [7:0] LC_RETURNED = 8'h09;

    // ************************************************************
    // Reply packet framing
    // ************************************************************
    localparam logic [7:0] RES_OK_FORM = 8'h00;
    localparam logic [7:0] RES_ERR_FORM = 8'h80;
    localparam logic [7:0] DATA_PACKET_START = 8'h81;
    localparam logic [7:0] PACKET_END = 8'h03;
    localparam logic [7:0] LEN_HIGH = 8'h00;
    localparam logic [7:0] LEN_LOW = 8'h0a;
    localparam logic [3:0] LAST_BYTE_IDX = 4'he;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DETAIL = 8'h08;
    localparam logic [7:0] REG_FAIL_ADDR = 8'h0c;
    localparam logic [7:0] REG_LIFECYCLE = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_ERR_BIT = 9;
    localparam int STAT_LC_CHANGED_BIT = 10;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    // Faults reported with a command, highest priority first
    typedef struct packed {
        logic unsup_cmd;
        logic packet;
        logic checksum;
        logic param;
        logic bad_addr;
        logic cert_area;
        logic not_accepted;
        logic lc_unmatched;
        logic hardware;
        logic protection;
        logic trusted;
        logic secure;
        logic flash_access;
        logic verify;
        logic flash_init;
    } bsr_fault_t;

    // One reply as sent
    typedef struct packed {
        logic [7:0] response_code;
        logic [7:0] status_code;
        logic [31:0] status_detail_word;
        logic [31:0] fail_addr;
        logic [7:0] sum;
    } bsr_reply_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_DONE = 2'b11
    } bsr_state_t;

endpackage
`default_nettype wire

// [bsr_reporter.sv]
// Functional notes
// - C0 unsupported, C1 format, C2 checksum
// - D0 parameter, D2 address outside boundaries
// - D3 certificate storage area invalid
// - D5 command not allowed in state
// - D6 lifecycle changed without reset
// - D7 abnormal stored memory value
// - DA protected area or prohibited action
// - DB trusted-system checker abnormality
// - E4 area beyond current privilege
// - E5 flash locked or driver fault
// - E8 read-back verify mismatch
// - E7 flash init failed; 00 normal
// - Nonzero status gives error response form
// - Detail: flash status, else all ones; the code sends the trusted-system word for DB
// - Clear flash status after reply sent
// - Failure address on flash error, else ones
// - Trusted-system codes for manifest faults
// - Trusted-system codes for CRC faults
// - One-byte lifecycle state codes
// - Response is command OR 00h/80h
// - Packet 81h start, 03h end, sum
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module bsr_reporter #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command outcome from the interpreter
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_cmd,
    input wire bsr_pkg::bsr_fault_t req_faults,
    input wire logic [2:0] req_ts_sel,
    input wire logic [31:0] flash_ctrl_status,
    input wire logic [31:0] flash_fail_addr,
    // Reply byte stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Flash side
    output logic flash_status_clear,
    output logic [7:0] lifecycle_state
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Fixed priority picks exactly one code
    function automatic logic [7:0] pick_status(input bsr_pkg::bsr_fault_t f);
        logic [7:0] s;
        s = bsr_pkg::STS_OK;
        if (f.unsup_cmd) s = bsr_pkg::STS_UNSUP_CMD;
        else if (f.packet) s = bsr_pkg::STS_PACKET;
        else if (f.checksum) s = bsr_pkg::STS_CHECKSUM;
        else if (f.param) s = bsr_pkg::STS_PARAM;
        else if (f.bad_addr) s = bsr_pkg::STS_BAD_ADDR;
        else if (f.cert_area) s = bsr_pkg::STS_CERT_AREA;
        else if (f.not_accepted) s = bsr_pkg::STS_NOT_ACCEPTED;
        else if (f.lc_unmatched) s = bsr_pkg::STS_LC_UNMATCHED;
        else if (f.hardware) s = bsr_pkg::STS_HARDWARE;
        else if (f.protection) s = bsr_pkg::STS_PROTECTION;
        else if (f.trusted) s = bsr_pkg::STS_TRUSTED;
        else if (f.secure) s = bsr_pkg::STS_SECURE;
        else if (f.flash_access) s = bsr_pkg::STS_FLASH_ACCESS;
        else if (f.verify) s = bsr_pkg::STS_VERIFY;
        else if (f.flash_init) s = bsr_pkg::STS_FLASH_INIT;
        return s;
    endfunction

    // Trusted-system detail selector
    function automatic logic [31:0] ts_word(input logic [2:0] sel);
        logic [31:0] w;
        case (sel)
            3'h0: w = bsr_pkg::TS_BAD_VERSION;
            3'h1: w = bsr_pkg::TS_LEN_RANGE;
            3'h2: w = bsr_pkg::TS_MISSING_FIELD;
            3'h3: w = bsr_pkg::TS_PAST_END;
            3'h4: w = bsr_pkg::TS_IMAGE_LEN;
            3'h5: w = bsr_pkg::TS_CRC_CALC;
            3'h6: w = bsr_pkg::TS_CRC_MISMATCH;
            default: w = bsr_pkg::UNUSED_WORD;
        endcase
        return w;
    endfunction

    // Two's complement of the byte sum from length to address
    function automatic logic [7:0] pkt_sum(input logic [7:0] res, input logic [7:0] sts,
                                           input logic [31:0] det, input logic [31:0] adr);
        logic [7:0] s;
        s = bsr_pkg::LEN_HIGH + bsr_pkg::LEN_LOW + res + sts;
        for (int i = 0; i < 4; i++) begin
            s = s + det[8*i +: 8] + adr[8*i +: 8];
        end
        return 8'(-s);
    endfunction

    // Byte at a position of the reply, words most significant first
    function automatic logic [7:0] pkt_byte(input logic [3:0] idx, input bsr_pkg::bsr_reply_t r);
        logic [7:0] b;
        case (idx)
            4'h0: b = bsr_pkg::DATA_PACKET_START;
            4'h1: b = bsr_pkg::LEN_HIGH;
            4'h2: b = bsr_pkg::LEN_LOW;
            4'h3: b = r.response_code;
            4'h4: b = r.status_code;
            4'h5: b = r.status_detail_word[31:24];
            4'h6: b = r.status_detail_word[23:16];
            4'h7: b = r.status_detail_word[15:8];
            4'h8: b = r.status_detail_word[7:0];
            4'h9: b = r.fail_addr[31:24];
            4'ha: b = r.fail_addr[23:16];
            4'hb: b = r.fail_addr[15:8];
            4'hc: b = r.fail_addr[7:0];
            4'hd: b = r.sum;
            4'he: b = bsr_pkg::PACKET_END;
            default: b = bsr_pkg::PACKET_END;
        endcase
        return b;
    endfunction

    function automatic logic lc_code_ok(input logic [7:0] c);
        return (c == bsr_pkg::LC_MANUFACTURER) || (c == bsr_pkg::LC_LOCKED_BOOT) ||
               (c == bsr_pkg::LC_RETURN_REQ) || (c == bsr_pkg::LC_RETURN_ACK) ||
               (c == bsr_pkg::LC_RETURNED);
    endfunction

    // ************************************************************
    // Reply assembly
    // ************************************************************
    bsr_pkg::bsr_state_t state_r;
    bsr_pkg::bsr_reply_t reply_r;
    bsr_pkg::bsr_reply_t reply_nxt;
    bsr_pkg::bsr_fault_t faults_eff;
    logic [3:0] idx_r;
    logic enable_r;
    logic lc_changed_r;
    logic [15:0] count_r;
    logic take;
    logic last_sent;
    logic req_cmd_hi_r;

    assign take = req_valid && req_ready;
    assign last_sent = (state_r == bsr_pkg::ST_SEND) && tx_valid && tx_ready &&
                       (idx_r == bsr_pkg::LAST_BYTE_IDX + 4'h1);

    // A pending lifecycle change is ORed into the caller's own flag
    always_comb begin
        faults_eff = req_faults;
        faults_eff.lc_unmatched = req_faults.lc_unmatched || lc_changed_r;
        reply_nxt.status_code = pick_status(faults_eff);
        reply_nxt.response_code = req_cmd | ((reply_nxt.status_code != bsr_pkg::STS_OK) ?
                                  bsr_pkg::RES_ERR_FORM : bsr_pkg::RES_OK_FORM);
        if (reply_nxt.status_code == bsr_pkg::STS_FLASH_ACCESS) begin
            reply_nxt.status_detail_word = flash_ctrl_status;
            reply_nxt.fail_addr = flash_fail_addr;
        end else if (reply_nxt.status_code == bsr_pkg::STS_TRUSTED) begin
            reply_nxt.status_detail_word = ts_word(req_ts_sel);
            reply_nxt.fail_addr = bsr_pkg::UNUSED_WORD;
        end else begin
            reply_nxt.status_detail_word = bsr_pkg::UNUSED_WORD;
            reply_nxt.fail_addr = bsr_pkg::UNUSED_WORD;
        end
        reply_nxt.sum = pkt_sum(reply_nxt.response_code, reply_nxt.status_code,
                                reply_nxt.status_detail_word, reply_nxt.fail_addr);
    end

    // Sequencer: latch, stream fifteen bytes, then release flash status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= bsr_pkg::ST_IDLE;
            reply_r <= '0;
            idx_r <= 4'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            req_ready <= 1'b0;
            flash_status_clear <= 1'b0;
        end else begin
            flash_status_clear <= 1'b0;
            case (state_r)
                bsr_pkg::ST_IDLE: begin
                    req_ready <= enable_r;
                    if (take) begin
                        req_ready <= 1'b0;
                        reply_r <= reply_nxt;
                        tx_valid <= 1'b1;
                        tx_data <= bsr_pkg::DATA_PACKET_START;
                        idx_r <= 4'h1;
                        state_r <= bsr_pkg::ST_SEND;
                    end
                end
                bsr_pkg::ST_SEND: begin
                    // Host back-pressure just holds the current byte
                    if (tx_ready) begin
                        if (last_sent) begin
                            tx_valid <= 1'b0;
                            flash_status_clear <= 1'b1;
                            state_r <= bsr_pkg::ST_DONE;
                        end else begin
                            tx_data <= pkt_byte(idx_r, reply_r);
                            idx_r <= idx_r + 4'h1;
                        end
                    end
                end
                bsr_pkg::ST_DONE: begin
                    state_r <= bsr_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= bsr_pkg::ST_IDLE;
                    tx_valid <= 1'b0;
                end
            endcase
        end
    end

    // Replies sent since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
        end else if (last_sent) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // ************************************************************
    // APB register file
    // ************************************************************
    logic apb_setup;
    logic apb_wr;
    logic bad_addr;
    logic bad_lc;
    logic [31:0] rd_word;

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite;
    assign bad_lc = pwrite && (paddr == bsr_pkg::REG_LIFECYCLE) && !lc_code_ok(pwdata[7:0]);

    always_comb begin
        bad_addr = 1'b0;
        rd_word = 32'h00000000;
        case (paddr)
            bsr_pkg::REG_CTRL: rd_word[bsr_pkg::CTRL_ENABLE_BIT] = enable_r;
            bsr_pkg::REG_STATUS: begin
                rd_word[7:0] = reply_r.status_code;
                rd_word[bsr_pkg::STAT_BUSY_BIT] = (state_r != bsr_pkg::ST_IDLE);
                rd_word[bsr_pkg::STAT_ERR_BIT] = (reply_r.status_code != bsr_pkg::STS_OK);
                rd_word[bsr_pkg::STAT_LC_CHANGED_BIT] = lc_changed_r;
            end
            bsr_pkg::REG_DETAIL: rd_word = reply_r.status_detail_word;
            bsr_pkg::REG_FAIL_ADDR: rd_word = reply_r.fail_addr;
            bsr_pkg::REG_LIFECYCLE: rd_word[7:0] = lifecycle_state;
            bsr_pkg::REG_COUNT: rd_word[15:0] = count_r;
            default: bad_addr = 1'b1;
        endcase
    end

    // Zero-wait answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && (bad_addr || bad_lc);
            prdata <= (apb_setup && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Control and lifecycle registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= bsr_pkg::CTRL_ENABLE_RST;
            lifecycle_state <= bsr_pkg::LC_MANUFACTURER;
            lc_changed_r <= 1'b0;
        end else if (apb_wr && !pslverr) begin
            if (paddr == bsr_pkg::REG_CTRL) begin
                enable_r <= pwdata[bsr_pkg::CTRL_ENABLE_BIT];
            end
            // Only a reset clears the pending-change mark
            if (paddr == bsr_pkg::REG_LIFECYCLE && pwdata[7:0] != lifecycle_state) begin
                lifecycle_state <= pwdata[7:0];
                lc_changed_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sod_first_a: assert property (take |=> tx_valid && tx_data == 8'h81)
        else $error("reply does not open with start byte");
    etx_last_a: assert property (tx_valid && idx_r == 4'hf |-> tx_data == 8'h03)
        else $error("reply does not close with end byte");
    res_form_a: assert property (tx_valid && idx_r == 4'h4 |->
        tx_data[7] == (reply_r.status_code != 8'h00 || req_cmd_hi_r))
        else $error("response form disagrees with status");
    unsup_code_a: assert property (take && req_faults.unsup_cmd |=>
        reply_r.status_code == 8'hc0)
        else $error("unsupported command not top priority");
    flash_word_a: assert property (take && req_faults == 15'h0004 && !lc_changed_r |=>
        reply_r.status_code == 8'he5 && reply_r.status_detail_word == $past(flash_ctrl_status)
        && reply_r.fail_addr == $past(flash_fail_addr))
        else $error("flash error words wrong");
    ok_ones_a: assert property (take && req_faults == 15'h0000 && !lc_changed_r |=>
        reply_r.status_code == 8'h00 && reply_r.fail_addr == 32'hffffffff
        && reply_r.status_detail_word == 32'hffffffff)
        else $error("normal reply words not all ones");
    clear_after_a: assert property (last_sent |=> flash_status_clear ##1 !flash_status_clear)
        else $error("flash status clear not one pulse after reply");
    lc_pending_a: assert property (take && lc_changed_r && req_faults[14:7] == 8'h00 |=>
        reply_r.status_code == 8'hd6)
        else $error("pending lifecycle change not reported");
    lc_valid_a: assert property (lc_code_ok(lifecycle_state))
        else $error("lifecycle register holds an undefined code");
    hold_byte_a: assert property (tx_valid && !tx_ready |=> $stable(tx_data) && tx_valid)
        else $error("byte changed under back-pressure");

    cov_flash_c: cover property (take && req_faults.flash_access ##[14:60] flash_status_clear);
    cov_ok_c: cover property (take && req_faults == 15'h0000 ##[14:60] last_sent);
    cov_stall_c: cover property ((tx_valid && !tx_ready) ##1 (tx_valid && tx_ready));

    // Command top bit, kept for the response-form check only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_cmd_hi_r <= 1'b0;
        end else if (take) begin
            req_cmd_hi_r <= req_cmd[7];
        end
    end

endmodule
`default_nettype wire

// [tb_boot_status_reporter.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_boot_status_reporter;
    localparam logic [7:0] CODES [0:14] = '{8'hc0, 8'hc1, 8'hc2, 8'hd0, 8'hd2, 8'hd3, 8'hd5,
        8'hd6, 8'hd7, 8'hda, 8'hdb, 8'he4, 8'he5, 8'he8, 8'he7};
    localparam logic [31:0] TSW [0:7] = '{32'haaaa0101, 32'haaaa0102, 32'haaaa0103,
        32'haaaa0104, 32'haaaa0105, 32'haaaa0200, 32'haaaa0300, 32'hffffffff};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, req_cmd = 8'h00, lcs;
    logic [31:0] pwdata = 32'h0, prdata, fstat = 32'h0, faddr = 32'h0, rd;
    logic pready, pslverr, req_valid = 1'b0, req_ready, tx_valid, tx_ready, fclr, err;
    logic slow = 1'b0, clr = 1'b0;
    logic [2:0] ts = 3'h0;
    logic [7:0] tx_data;
    logic [7:0] got [0:15];
    logic [4:0] cnt;
    bsr_pkg::bsr_fault_t faults = '0;
    int errors = 0, checked = 0, cyc = 0, clrs = 0;
    bsr_reporter u_bsr_reporter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_faults(faults), .req_ts_sel(ts), .flash_ctrl_status(fstat),
        .flash_fail_addr(faddr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .flash_status_clear(fclr), .lifecycle_state(lcs));
    bsr_host_model u_bsr_host_model (.pclk(pclk), .presetn(presetn), .slow(slow), .clr(clr),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .got(got), .cnt(cnt));
    // ****************************************
    // Clock, clear-pulse count and hang guard
    // ****************************************
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        clrs = clrs + (fclr === 1'b1);
        cyc = cyc + 1;
        if (cyc > 20000) begin
            errors = errors + 1;
            wrap_up();
        end
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; pready is sampled at the edge, never assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Present one outcome, collect the reply and judge every byte
    task automatic reply(input logic [7:0] cmd, input bsr_pkg::bsr_fault_t f,
            input logic [14:0] xf, input logic [2:0] t, input logic s);
        logic [7:0] sts, sum;
        logic [31:0] det, adr;
        logic [7:0] e [0:14];
        int n;
        sts = 8'h00; det = 32'hffffffff; adr = 32'hffffffff; sum = 8'h00;
        for (int i = 14; i >= 0; i--) if ((f[i] || xf[i]) && sts == 8'h00) sts = CODES[14-i];
        if (sts == 8'he5) begin det = {24'h12a0b0, cmd}; adr = {8'h00, cmd, 16'h4000}; end
        if (sts == 8'hdb) det = TSW[t];
        e = '{8'h81, 8'h00, 8'h0a, cmd | ((sts != 8'h00) ? 8'h80 : 8'h00), sts, det[31:24],
            det[23:16], det[15:8], det[7:0], adr[31:24], adr[23:16], adr[15:8], adr[7:0],
            8'h00, 8'h03};
        for (int i = 1; i < 13; i++) sum = sum - e[i];
        e[13] = sum;
        n = clrs;
        slow <= s; clr <= 1'b1; req_valid <= 1'b1; req_cmd <= cmd; faults <= f; ts <= t;
        fstat <= {24'h12a0b0, cmd}; faddr <= {8'h00, cmd, 16'h4000};
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0; clr <= 1'b0; fstat <= 32'h0; faddr <= 32'h0;
        do @(posedge pclk); while (req_ready !== 1'b1);
        chk("byte count", 32'd15, {27'h0, cnt});
        for (int i = 0; i < 15; i++) chk("reply byte", {24'h0, e[i]}, {24'h0, got[i]});
        chk("status clear pulses", n + 1, clrs);
        apb(1'b0, 8'h04, 32'h0);
        chk("status register", {21'h0, xf[7], sts != 8'h00, 1'b0, sts}, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("detail register", det, rd);
        apb(1'b0, 8'h0c, 32'h0);
        chk("fail address register", adr, rd);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk("lifecycle reset", 32'h04, {24'h0, lcs});
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        apb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge pclk);
        chk("ready while disabled", 32'h0, {31'h0, req_ready});
        apb(1'b1, 8'h00, 32'h1);
    endtask
    task automatic t_codes();
        for (int k = 0; k < 15; k++) reply(8'h13, 15'h1 << (14 - k), 15'h0, 3'h0, k[0]);
        reply(8'h71, '0, 15'h0, 3'h0, 1'b0);
        chk("example sum", 32'h8d, {24'h0, got[13]});
    endtask
    task automatic t_prio();
        reply(8'h15, '1, 15'h0, 3'h0, 1'b1);
        reply(8'h12, 15'h0007, 15'h0, 3'h0, 1'b0);
        reply(8'h18, 15'h0003, 15'h0, 3'h0, 1'b1);
    endtask
    task automatic t_trusted();
        for (int t = 0; t < 8; t++) reply(8'h27, 15'h0010, 15'h0, t[2:0], t[0]);
    endtask
    task automatic t_lc();
        apb(1'b1, 8'h10, 32'h05);
        chk("bad lifecycle refused", 32'h1, {31'h0, err});
        chk("lifecycle kept", 32'h04, {24'h0, lcs});
        apb(1'b1, 8'h10, 32'h07);
        chk("lifecycle write error", 32'h0, {31'h0, err});
        @(posedge pclk);
        chk("lifecycle written", 32'h07, {24'h0, lcs});
        apb(1'b0, 8'h10, 32'h0);
        chk("lifecycle register", 32'h07, rd);
        reply(8'h2c, '0, 15'h0080, 3'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk("reply count", 32'd28, rd);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_prio();
        t_trusted();
        t_lc();
        wrap_up();
    end
endmodule
`default_nettype wire
